// file: hw/epdo_top.sv
// encoder pulse divider with quadrature and origin outputs
//
// Functional notes
// [RL1] The count setting accepts 16 and up in steps set by its band, defaults to 2048, and is taken only at restart.
// [RL2] Encoder counts are scaled by the count setting so each revolution yields that many output pulses.
// [RL3] A 13-bit encoder allows 16 to 2048 in unit steps with a 6000 rpm limit.
// [RL4] 17-bit and 20-bit encoders allow 16 to 16384 step 1 at 6000 rpm and 16386 to 32768 step 2 at 3000 rpm.
// [RL5] A 20-bit encoder also allows up to 65536 step 4, 131072 step 8 and 262144 step 16 at 1500, 750, 375 rpm.
// [RL6] A count outside the range for the fitted resolution raises the setting error alarm.
// [RL7] A count that is not a multiple of its band's step raises the setting error alarm.
// [RL8] The output pulse rate is capped near 1.6 Mpps, which sets the speed limit of each band.
// [RL9] Motor speed above the band's speed limit raises the overspeed alarm.
// [RL10] Two outputs form a quadrature pair 90 degrees apart, each carrying the configured pulses per revolution.
// [RL11] One origin pulse per revolution, as wide as one phase a pulse.
// [RL12] Reverse rotation mode leaves the output phase form unchanged.
// [RL13] A fractional accumulator adds four times the count per encoder count and steps once each time it reaches the resolution.
`include "epdo_regs.svh"

module epdo_top #(
    parameter int WIN_CYC = `EPDO_WIN_CYC
) (
    input wire logic clk, // 10 MHz system clock
    input wire logic rst, // sync reset, active high; release is the restart
    input wire logic enc_step, // one encoder count, one-cycle pulse
    input wire logic enc_fwd, // direction of enc_step, 1 = counting up
    input wire logic enc_index, // encoder once-per-turn marker pulse
    input wire logic [1:0] enc_res_sel, // 0 = 13, 1 = 17, 2 = 20 bit encoder
    input wire logic [29:0] output_pulse_count_setting, // pulses per revolution
    input wire logic cnt_setting_valid, // low selects the default count
    output logic quad_out_a, // quadrature phase a
    output logic quad_out_b, // quadrature phase b
    output logic origin_pulse_out, // once-per-revolution origin pulse
    output logic setting_error_alarm, // illegal count, held until reset
    output logic overspeed_alarm, // band speed exceeded, held until reset
    output logic running // divider active
);
    epdo_pkg::epdo_state_t state_r;
    epdo_pkg::epdo_res_t res_r;
    logic [29:0] cnt_r;
    logic [2:0] band;
    logic [29:0] band_mask;
    logic [29:0] res_max;
    logic [4:0] res_bits;
    logic cfg_bad;
    logic [`EPDO_ACC_W-1:0] acc_r;
    logic [`EPDO_ACC_W-1:0] acc_nxt;
    logic [`EPDO_ACC_W-1:0] res_cnt;
    logic [`EPDO_ACC_W-1:0] inc;
    logic [`EPDO_ACC_W:0] sum;
    logic q_step;
    logic q_step_r;
    logic q_fwd_r;
    logic a_prev_r;
    logic armed_r;
    logic [31:0] win_r;
    logic [`EPDO_SPD_W-1:0] spd_r;
    logic [63:0] lim_full;
    logic [`EPDO_SPD_W-1:0] lim;

    // band and granularity of the latched count
    // [RL4] band edges
    // [RL5] extra bands
    always_comb begin
        if (cnt_r <= `EPDO_BAND0_MAX) begin
            band = 3'h0;
        end else if (cnt_r <= `EPDO_BAND1_MAX) begin
            band = 3'h1;
        end else if (cnt_r <= `EPDO_BAND2_MAX) begin
            band = 3'h2;
        end else if (cnt_r <= `EPDO_BAND3_MAX) begin
            band = 3'h3;
        end else begin
            band = 3'h4;
        end
        band_mask = (30'h0000_0001 << band) - 30'h0000_0001;
    end

    // [RL3] resolution limits
    always_comb begin
        case (res_r)
            epdo_pkg::epdo_res13: begin
                res_max = `EPDO_MAX_13B;
                res_bits = `EPDO_BITS_13B;
            end
            epdo_pkg::epdo_res17: begin
                res_max = `EPDO_MAX_17B;
                res_bits = `EPDO_BITS_17B;
            end
            epdo_pkg::epdo_res20: begin
                res_max = `EPDO_MAX_20B;
                res_bits = `EPDO_BITS_20B;
            end
            default: begin
                res_max = 30'h0000_0000;
                res_bits = `EPDO_BITS_13B;
            end
        endcase
        res_cnt = `EPDO_ACC_W'(1) << res_bits;
    end

    // [RL6] range check
    // [RL7] step multiple
    assign cfg_bad = (cnt_r < `EPDO_CNT_MIN) || (cnt_r > res_max) || ((cnt_r & band_mask) != 30'h0000_0000);

    // [RL1] latch at restart
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= epdo_pkg::epdo_st_load;
            cnt_r <= `EPDO_CNT_DEFAULT;
            res_r <= epdo_pkg::epdo_res13;
            setting_error_alarm <= 1'b0;
            running <= 1'b0;
        end else begin
            case (state_r)
                epdo_pkg::epdo_st_load: begin
                    // later changes of the inputs are ignored until the next reset
                    cnt_r <= cnt_setting_valid ? output_pulse_count_setting : `EPDO_CNT_DEFAULT;
                    res_r <= epdo_pkg::epdo_res_t'(enc_res_sel);
                    state_r <= epdo_pkg::epdo_st_check;
                end
                epdo_pkg::epdo_st_check: begin
                    if (cfg_bad) begin
                        setting_error_alarm <= 1'b1;
                        state_r <= epdo_pkg::epdo_st_halt;
                    end else begin
                        running <= 1'b1;
                        state_r <= epdo_pkg::epdo_st_run;
                    end
                end
                epdo_pkg::epdo_st_run: begin
                    state_r <= epdo_pkg::epdo_st_run;
                end
                epdo_pkg::epdo_st_halt: begin
                    state_r <= epdo_pkg::epdo_st_halt;
                end
                default: begin
                    state_r <= epdo_pkg::epdo_st_halt;
                end
            endcase
        end
    end

    // four quadrature states per output pulse, so 4n never exceeds the resolution
    assign inc = {cnt_r[`EPDO_ACC_W-3:0], 2'h0};
    assign sum = {1'b0, acc_r} + {1'b0, inc};

    // [RL13] fractional accumulator
    // [RL2] scale by the count
    always_comb begin
        acc_nxt = acc_r;
        q_step = 1'b0;
        if (running && enc_step) begin
            if (enc_fwd) begin
                if (sum >= {1'b0, res_cnt}) begin
                    acc_nxt = `EPDO_ACC_W'(sum - {1'b0, res_cnt});
                    q_step = 1'b1;
                end else begin
                    acc_nxt = sum[`EPDO_ACC_W-1:0];
                end
            end else if (acc_r >= inc) begin
                acc_nxt = acc_r - inc;
            end else begin
                acc_nxt = acc_r + res_cnt - inc;
                q_step = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            acc_r <= `EPDO_ACC_W'(0);
            q_step_r <= 1'b0;
            q_fwd_r <= 1'b1;
        end else begin
            acc_r <= acc_nxt;
            q_step_r <= q_step;
            // [RL12] direction ignores reverse mode
            q_fwd_r <= enc_fwd;
        end
    end

    // [RL10] quadrature pair
    epdo_quad_gen u_quad (
        .clk(clk),
        .rst(rst),
        .step(q_step_r),
        .fwd(q_fwd_r),
        .out_a(quad_out_a),
        .out_b(quad_out_b)
    );

    // [RL11] origin pulse spans one phase a high
    always_ff @(posedge clk) begin
        if (rst) begin
            a_prev_r <= 1'b0;
            armed_r <= 1'b0;
            origin_pulse_out <= 1'b0;
        end else begin
            a_prev_r <= quad_out_a;
            if (quad_out_a && !a_prev_r && armed_r) begin
                origin_pulse_out <= 1'b1;
                armed_r <= enc_index && running;
            end else begin
                if (!quad_out_a && a_prev_r) begin
                    origin_pulse_out <= 1'b0;
                end
                if (enc_index && running) begin
                    armed_r <= 1'b1;
                end
            end
        end
    end

    // [RL8] rate ceiling via band limit
    // [RL9] speed limit per band
    always_comb begin
        lim_full = ((64'h1 << res_bits) * (`EPDO_RPM_BASE >> band) * 64'(WIN_CYC))
            / (`EPDO_SEC_PER_MIN * 64'(`EPDO_CLK_HZ));
        lim = `EPDO_SPD_W'(lim_full);
    end

    // speed sampled over a fixed window; coarse, but alarms need no fine resolution
    always_ff @(posedge clk) begin
        if (rst) begin
            win_r <= 32'h0000_0000;
            spd_r <= `EPDO_SPD_W'(0);
            overspeed_alarm <= 1'b0;
        end else if (running) begin
            if (win_r >= 32'(WIN_CYC - 1)) begin
                win_r <= 32'h0000_0000;
                spd_r <= `EPDO_SPD_W'(enc_step);
                // [RL9] raise overspeed
                if (spd_r > lim) begin
                    overspeed_alarm <= 1'b1;
                end
            end else begin
                win_r <= win_r + 32'h0000_0001;
                if (enc_step && spd_r != {`EPDO_SPD_W{1'b1}}) begin
                    spd_r <= spd_r + `EPDO_SPD_W'(1);
                end
            end
        end
    end
endmodule

// file: hw/epdo_regs.svh
// constants for the encoder pulse divider output block
`ifndef EPDO_REGS_SVH
`define EPDO_REGS_SVH

`define EPDO_CLK_HZ 10000000
`define EPDO_WIN_US 1000
`define EPDO_WIN_CYC (`EPDO_WIN_US * (`EPDO_CLK_HZ / 1000000))
`define EPDO_CNT_DEFAULT 30'h0000_0800
`define EPDO_CNT_MIN 30'h0000_0010
`define EPDO_BAND0_MAX 30'h0000_4000
`define EPDO_BAND1_MAX 30'h0000_8000
`define EPDO_BAND2_MAX 30'h0001_0000
`define EPDO_BAND3_MAX 30'h0002_0000
`define EPDO_MAX_13B 30'h0000_0800
`define EPDO_MAX_17B 30'h0000_8000
`define EPDO_MAX_20B 30'h0004_0000
`define EPDO_BITS_13B 5'h0D
`define EPDO_BITS_17B 5'h11
`define EPDO_BITS_20B 5'h14
`define EPDO_RPM_BASE 64'h0000_0000_0000_1770
`define EPDO_SEC_PER_MIN 64'h0000_0000_0000_003C
`define EPDO_ACC_W 21
`define EPDO_SPD_W 24

`endif

// file: hw/epdo_pkg.sv
// types shared by the encoder pulse divider output block
package epdo_pkg;
    typedef enum logic [1:0] {
        epdo_res13,
        epdo_res17,
        epdo_res20,
        epdo_res_bad
    } epdo_res_t;

    typedef enum logic [1:0] {
        epdo_st_load,
        epdo_st_check,
        epdo_st_run,
        epdo_st_halt
    } epdo_state_t;
endpackage

// file: hw/epdo_quad_gen.sv
// quadrature phase generator, one state step per strobe
module epdo_quad_gen (
    input wire logic clk, // system clock
    input wire logic rst, // sync reset, active high
    input wire logic step, // advance one quadrature state
    input wire logic fwd, // direction of the step
    output logic out_a, // phase a
    output logic out_b // phase b
);
    logic [1:0] phase_r;
    logic [1:0] phase_nxt;

    always_comb begin
        phase_nxt = phase_r;
        if (step) begin
            phase_nxt = fwd ? phase_r + 2'h1 : phase_r - 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            phase_r <= 2'h0;
            out_a <= 1'b0;
            out_b <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            // a leads b by a quarter period when stepping forward
            out_a <= (phase_nxt == 2'h1) || (phase_nxt == 2'h2);
            out_b <= phase_nxt[1];
        end
    end
endmodule

// file: verification/epdo_top_monitor.sv
// assertion checker for the pulse divider top
module epdo_top_monitor #(
    parameter int WIN_CYC = 10000
) (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic enc_step, // count
    input wire logic enc_fwd, // dir
    input wire logic enc_index, // marker
    input wire logic [1:0] enc_res_sel, // res
    input wire logic [29:0] output_pulse_count_setting, // count
    input wire logic cnt_setting_valid, // use count
    input wire logic quad_out_a, // phase a
    input wire logic quad_out_b, // phase b
    input wire logic origin_pulse_out, // origin
    input wire logic setting_error_alarm, // bad count
    input wire logic overspeed_alarm, // too fast
    input wire logic running // active
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_load_answer: assert property ($fell(rst) ##1 !rst ##1 !rst |-> running != setting_error_alarm)
        else $error("load gave no single answer");
    a_err_sticky: assert property (setting_error_alarm |=> setting_error_alarm && !running)
        else $error("setting alarm dropped");
    a_err_halts: assert property (setting_error_alarm |-> !quad_out_a && !quad_out_b && !origin_pulse_out)
        else $error("outputs move after setting alarm");
    a_one_phase: assert property (!($changed(quad_out_a) && $changed(quad_out_b)))
        else $error("both phases moved");
    a_step_delay: assert property ($changed(quad_out_a) || $changed(quad_out_b)
        |-> $past(enc_step, 2) && $past(running, 2))
        else $error("phase moved without a count");
    a_phase_dir: assert property ($rose(quad_out_a) |-> quad_out_b == !$past(enc_fwd, 2))
        else $error("phase order wrong");
    a_origin_rise: assert property ($rose(origin_pulse_out) |-> $past(quad_out_a) && !$past(quad_out_a, 2))
        else $error("origin not aligned to phase a");
    a_over_sticky: assert property (overspeed_alarm |=> overspeed_alarm && running)
        else $error("overspeed alarm dropped");
endmodule

bind epdo_top epdo_top_monitor #(.WIN_CYC(WIN_CYC)) u_mon (.clk(clk), .rst(rst), .enc_step(enc_step),
    .enc_fwd(enc_fwd), .enc_index(enc_index), .enc_res_sel(enc_res_sel),
    .output_pulse_count_setting(output_pulse_count_setting), .cnt_setting_valid(cnt_setting_valid),
    .quad_out_a(quad_out_a), .quad_out_b(quad_out_b), .origin_pulse_out(origin_pulse_out),
    .setting_error_alarm(setting_error_alarm), .overspeed_alarm(overspeed_alarm), .running(running));

// file: verification/epdo_host_model.sv
// host side position counter fed by the quadrature pair
module epdo_host_model (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic qa, // phase a
    input wire logic qb, // phase b
    input wire logic org, // origin
    output int pos, // edge count
    output int org_cnt, // origins
    output int bad_cnt // skipped states
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] prev_r;
    logic org_r;
    logic [1:0] dif;
    // gray index 00,10,11,01 maps to 0..3
    assign dif = {qb, qa ^ qb} - prev_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_r <= 2'h0;
            org_r <= 1'b0;
            pos <= 0;
            org_cnt <= 0;
            bad_cnt <= 0;
        end else begin
            prev_r <= {qb, qa ^ qb};
            org_r <= org;
            if (dif == 2'h1) pos <= pos + 1;
            if (dif == 2'h3) pos <= pos - 1;
            if (dif == 2'h2) bad_cnt <= bad_cnt + 1;
            if (org && !org_r) org_cnt <= org_cnt + 1;
        end
    end
endmodule

// file: verification/epdo_top_tb.sv
// self-checking bench for the pulse divider
module epdo_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic step = 1'b0;
    logic fwd = 1'b1;
    logic idx = 1'b0;
    logic [1:0] res = 2'h0;
    logic [29:0] cnt = 30'h0;
    logic vld = 1'b0;
    logic qa, qb, org, serr, ospd, run_o;
    int pos, org_cnt, bad_cnt;
    int error_cnt = 0;
    int cmp_count = 0;
    always #50 clk = ~clk;
    epdo_top #(.WIN_CYC(500)) u_dut (.clk(clk), .rst(rst), .enc_step(step), .enc_fwd(fwd),
        .enc_index(idx), .enc_res_sel(res), .output_pulse_count_setting(cnt), .cnt_setting_valid(vld),
        .quad_out_a(qa), .quad_out_b(qb), .origin_pulse_out(org), .setting_error_alarm(serr),
        .overspeed_alarm(ospd), .running(run_o));
    epdo_host_model u_host (.clk(clk), .rst(rst), .qa(qa), .qb(qb), .org(org), .pos(pos),
        .org_cnt(org_cnt), .bad_cnt(bad_cnt));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %0h not %0h", $time, got, exp);
        end
    endtask
    task automatic cfg(input logic [1:0] r, input logic [29:0] c, input logic v);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        res <= r;
        cnt <= c;
        vld <= v;
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic go(input int n, input logic f);
        @(posedge clk);
        repeat (n) begin
            step <= 1'b1;
            fwd <= f;
            @(posedge clk);
        end
        step <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic t_default();
        cfg(2'h0, 30'h5, 1'b0);
        chk({serr, run_o}, 2'h1);
        go(8192, 1'b1);
        chk(pos, 32'h2000);
        chk(ospd, 1'b1);
    endtask
    task automatic t_unit_band();
        cfg(2'h1, 30'h4000, 1'b1);
        @(posedge clk);
        cnt <= 30'h3;
        go(1000, 1'b1);
        chk({ospd, serr, run_o}, 3'h1);
        chk(pos, 32'h1F4);
    endtask
    task automatic t_overspeed();
        cfg(2'h1, 30'h8000, 1'b1);
        go(1500, 1'b1);
        chk(pos, 32'h5DC);
        chk(ospd, 1'b1);
    endtask
    task automatic t_table();
        logic [32:0] cs [14] = '{{2'h0, 30'h801, 1'b1}, {2'h0, 30'h10, 1'b0}, {2'h0, 30'hF, 1'b1},
            {2'h1, 30'h61A8, 1'b0}, {2'h1, 30'h61A9, 1'b1}, {2'h1, 30'h4001, 1'b1},
            {2'h1, 30'h4002, 1'b0}, {2'h1, 30'h8002, 1'b1}, {2'h2, 30'h8006, 1'b1},
            {2'h2, 30'h10008, 1'b0}, {2'h2, 30'h20018, 1'b1}, {2'h2, 30'h40000, 1'b0},
            {2'h2, 30'h40010, 1'b1}, {2'h3, 30'h800, 1'b1}};
        foreach (cs[i]) begin
            cfg(cs[i][32:31], cs[i][30:1], 1'b1);
            chk({serr, run_o}, {cs[i][0], !cs[i][0]});
            go(40, 1'b1);
            if (cs[i][0]) chk({qa, qb, org, pos[0]}, 4'h0);
        end
    endtask
    task automatic t_origin_rev();
        cfg(2'h0, 30'h10, 1'b1);
        @(posedge clk);
        idx <= 1'b1;
        @(posedge clk);
        idx <= 1'b0;
        go(8192, 1'b1);
        chk(org_cnt, 32'h1);
        chk(pos, 32'h40);
        go(256, 1'b0);
        chk(pos, 32'h3E);
        chk(bad_cnt, 32'h0);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        t_default();
        t_unit_band();
        t_overspeed();
        t_table();
        t_origin_rev();
        wrap_up();
    end
    // whole run is near 20k cycles
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end
endmodule
